// file: shared/fcs_pkg.sv
// Function
// R1: security read takes 3/4 address bytes then one dummy byte, sampled on rising clock
// R2: security read shifts bytes out on falling edges, offset advancing after each byte
// R3: byte offset wraps from last location to zero; stream runs until select rises
// R4: address upper byte zero, bits 15-12 pick register 1..3, bit 11 zero
// R5: addresses are 24-bit unless four-byte mode makes them 32-bit
// R6: reset needs enable opcode in one frame then reset opcode in the next
// R7: accepted reset aborts work and clears volatile flags, suspend and power-down
// R8: every command is refused during the reset recovery interval
// R9: host should check busy and suspend flags before issuing a reset
// R10: suspend accepted only while busy with both suspend flags clear
// R11: accepted suspend sets its flag at once, busy clears within suspend latency
// R12: program suspend rejects status writes, security erase/program, erases, page programs
// R13: erase suspend rejects status writes, security erase and all erases
// R14: resume only when suspended and idle; flag clears now, busy sets within 200ns
// R15: power-down runs only if select rises right after the eighth opcode bit
// R16: power-down entered after entry delay; then only wake and reset accepted
// R17: power-down during a program, erase or write cycle is discarded
// R18: wake opcode alone, then no command accepted for the plain wake time
// R19: wake opcode plus three dummy bytes streams the id byte repeatedly
// R20: waking with the id form needs the longer wake time
// R21: wake/id opcode is ignored while busy
// R22: timed intervals are cycle counters gating the command decode
`default_nettype none
package fcs_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  // ==========================================================
  // frame lengths in received bits
  localparam logic [6:0] OPC_BITS = 7'h08;
  localparam logic [6:0] ADDR3_END = 7'h20;
  localparam logic [6:0] ADDR4_END = 7'h28;
  localparam logic [6:0] SEC_HDR3 = 7'h28;
  localparam logic [6:0] SEC_HDR4 = 7'h30;
  localparam logic [6:0] ID_HDR = 7'h20;
  localparam logic [6:0] BITS_MAX = 7'h7f;
  // ==========================================================
  // security register storage
  localparam logic [12:0] SEC_LIMIT = 13'h1800;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // arbitrary identity value
  localparam logic [7:0] DEVICE_ID = 8'h5a;
  // ==========================================================
  // timing, 125 MHz clock
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RST_NS = 30000;
  localparam int T_SUS_NS = 20000;
  localparam int T_RESUME_NS = 200;
  localparam int T_DP_NS = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RES2_NS = 8000;
  localparam logic [11:0] RST_CYC =
    12'((T_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] SUS_CYC = 12'((T_SUS_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [11:0] RESUME_CYC =
    12'((T_RESUME_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [11:0] DP_CYC =
    12'((T_DP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] RES1_CYC =
    12'((T_RES1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] RES2_CYC =
    12'((T_RES2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // ==========================================================
  // reset values
  localparam logic [7:0] CONT_READ_RST = 8'h00;
  localparam logic [2:0] WRAP_RST = 3'h0;
  localparam logic [11:0] TMR_RST = 12'h000;
  typedef enum logic [2:0] {
    FCS_IDLE = 3'b000,
    FCS_PD_ENTRY = 3'b001,
    FCS_PD = 3'b011,
    FCS_WAKE = 3'b010,
    FCS_RST_REC = 3'b110
  } fcs_mode_t;
endpackage
`default_nettype wire

// file: src/fcs_secreg_mem.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_secreg_mem (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [12:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [12:0] rdAddr,
  output logic [7:0] rdData
);
  // ==========================================================
  // three registers of 2048 bytes; filled from the system clock,
  // read asynchronously by the link side
  logic [7:0] mem [0:fcs_pkg::SEC_LIMIT-1];
  wire wrInRange = wrAddr < fcs_pkg::SEC_LIMIT;
  wire rdInRange = rdAddr < fcs_pkg::SEC_LIMIT;

  always_ff @(posedge clock) begin
    if (wrEn && wrInRange) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = rdInRange ? mem[rdAddr] : fcs_pkg::ERASED_BYTE;
endmodule
`default_nettype wire

// file: src/fcs_cmd_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_cmd_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic spiCsN,
  input wire logic spiSi,
  output logic spiSo,
  output logic spiSoOe,
  input wire logic addr4Mode,
  input wire logic opStart,
  input wire logic opIsErase,
  input wire logic opDone,
  input wire logic welSet,
  input wire logic volLoad,
  input wire logic [7:0] contReadIn,
  input wire logic [2:0] wrapIn,
  input wire logic secWrEn,
  input wire logic [12:0] secWrAddr,
  input wire logic [7:0] secWrData,
  output logic wipFlag,
  output logic suspProgFlag,
  output logic suspEraseFlag,
  output logic welFlag,
  output logic [7:0] contReadBits,
  output logic [2:0] wrapBits,
  output logic powerDown,
  output logic cmdBlocked,
  output logic engAbort,
  output logic fwdValid,
  output logic [7:0] fwdOpcode
);
  // ==========================================================
  // link side: bit counter, cleared while select is high
  wire frameRstN = rst_n & ~spiCsN;
  logic [6:0] bitCnt_r;
  logic [6:0] bitCnt_nxt;
  logic [7:0] resOp_r;
  logic [6:0] resBits_r;
  logic frameTog_r;
  logic [31:0] addrSh_r;
  logic rdOkS1_r;
  logic rdOkS2_r;
  logic idOkS1_r;
  logic idOkS2_r;
  logic a4S1_r;
  logic a4S2_r;
  logic rdOk_r;
  logic idOk_r;
  logic addr4Lvl_r;

  assign bitCnt_nxt = (bitCnt_r == fcs_pkg::BITS_MAX) ? bitCnt_r :
    bitCnt_r + 7'h01;
  wire inOpcode = bitCnt_r < fcs_pkg::OPC_BITS;
  wire [6:0] addrEnd = a4S2_r ? fcs_pkg::ADDR4_END : fcs_pkg::ADDR3_END; // R5
  wire inAddr = bitCnt_r < addrEnd;

  always_ff @(posedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      bitCnt_r <= '0;
      addrSh_r <= '0;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      if (inAddr) begin
        addrSh_r <= {addrSh_r[30:0], spiSi}; // R1
      end
    end
  end

  // frame outcome survives select rising so the system side can read it
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      resOp_r <= '0;
      resBits_r <= '0;
      frameTog_r <= 1'b0;
    end else begin
      if (inOpcode) begin
        resOp_r <= {resOp_r[6:0], spiSi};
      end
      resBits_r <= bitCnt_nxt;
      if (bitCnt_r == '0) begin
        frameTog_r <= ~frameTog_r;
      end
    end
  end

  // levels from the system side; stable long before the opcode ends
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rdOkS1_r <= 1'b0;
      rdOkS2_r <= 1'b0;
      idOkS1_r <= 1'b0;
      idOkS2_r <= 1'b0;
      a4S1_r <= 1'b0;
      a4S2_r <= 1'b0;
    end else begin
      rdOkS1_r <= rdOk_r;
      rdOkS2_r <= rdOkS1_r;
      idOkS1_r <= idOk_r;
      idOkS2_r <= idOkS1_r;
      a4S1_r <= addr4Lvl_r;
      a4S2_r <= a4S1_r;
    end
  end

  // ==========================================================
  // link side: serial output on falling edges
  logic stream_r;
  logic idMode_r;
  logic [2:0] bitIdx_r;
  logic [10:0] rdOff_r;
  logic [1:0] secSel_r;
  logic secVal_r;
  logic [7:0] curByte_r;
  logic so_r;
  logic [7:0] memData;

  wire [6:0] secHdr = a4S2_r ? fcs_pkg::SEC_HDR4 : fcs_pkg::SEC_HDR3; // R1
  wire upperZero = a4S2_r ? (addrSh_r[31:16] == '0) :
    (addrSh_r[23:16] == '0);
  wire [3:0] regNum = addrSh_r[15:12];
  wire addrDecOk = upperZero & (regNum != 4'h0) & (regNum < 4'h4) &
    ~addrSh_r[11]; // R4
  wire startSec = (resOp_r == fcs_pkg::OP_SEC_READ) & rdOkS2_r &
    (bitCnt_r == secHdr) & ~stream_r;
  wire startId = (resOp_r == fcs_pkg::OP_WAKE_ID) & idOkS2_r &
    (bitCnt_r == fcs_pkg::ID_HDR) & ~stream_r; // R19 R21
  wire startAny = startSec | startId;
  wire loadByte = startAny | (stream_r & (bitIdx_r == 3'h0));
  wire [10:0] offSel = startSec ? addrSh_r[10:0] : rdOff_r;
  wire [1:0] selSel = startSec ? (regNum[1:0] - 2'h1) : secSel_r;
  wire valSel = startSec ? addrDecOk : secVal_r;
  wire idSel = startId | (idMode_r & ~startSec);
  wire [7:0] byteSrc = idSel ? fcs_pkg::DEVICE_ID :
    (valSel ? memData : fcs_pkg::ERASED_BYTE);

  fcs_secreg_mem u_mem (
    .clock(clock),
    .wrEn(secWrEn),
    .wrAddr(secWrAddr),
    .wrData(secWrData),
    .rdAddr({selSel, offSel}),
    .rdData(memData)
  );

  always_ff @(negedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      stream_r <= 1'b0;
      idMode_r <= 1'b0;
      secSel_r <= '0;
      secVal_r <= 1'b0;
    end else if (startAny) begin
      stream_r <= 1'b1;
      idMode_r <= startId;
      secSel_r <= selSel;
      secVal_r <= addrDecOk;
    end
  end

  // offset counter is 11 bits, so it wraps from the last byte to zero
  always_ff @(negedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      bitIdx_r <= '0;
      rdOff_r <= '0;
      curByte_r <= '0;
      so_r <= 1'b0;
    end else if (loadByte) begin
      curByte_r <= byteSrc; // R2
      so_r <= byteSrc[7];
      rdOff_r <= offSel + 11'h001; // R2 R3
      bitIdx_r <= 3'h1;
    end else if (stream_r) begin
      so_r <= curByte_r[3'h7 - bitIdx_r]; // R19
      bitIdx_r <= bitIdx_r + 3'h1;
    end
  end

  assign spiSo = so_r;
  assign spiSoOe = stream_r & ~spiCsN;

  // ==========================================================
  // system side: frame end detection
  logic csS1_r;
  logic csS2_r;
  logic csPrev_r;
  logic tgS1_r;
  logic tgS2_r;
  logic tgSeen_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csPrev_r <= 1'b1;
      tgS1_r <= 1'b0;
      tgS2_r <= 1'b0;
      tgSeen_r <= 1'b0;
    end else begin
      csS1_r <= spiCsN;
      csS2_r <= csS1_r;
      csPrev_r <= csS2_r;
      tgS1_r <= frameTog_r;
      tgS2_r <= tgS1_r;
      if (csS2_r & ~csPrev_r) begin
        tgSeen_r <= tgS2_r;
      end
    end
  end

  // a frame with no clock edge leaves the toggle alone and is dropped;
  // the outcome words are quiet once select is high, so this sample is safe
  wire frameEnd = csS2_r & ~csPrev_r & (tgS2_r != tgSeen_r);
  wire [7:0] fOp = resOp_r;
  wire full8 = resBits_r >= fcs_pkg::OPC_BITS;
  wire isRstEn = full8 & (fOp == fcs_pkg::OP_RST_EN);
  wire isRst = full8 & (fOp == fcs_pkg::OP_RST);
  wire isSusp = full8 & (fOp == fcs_pkg::OP_SUSPEND);
  wire isResume = full8 & (fOp == fcs_pkg::OP_RESUME);
  wire isPd = full8 & (fOp == fcs_pkg::OP_POWER_DOWN);
  wire isWake = full8 & (fOp == fcs_pkg::OP_WAKE_ID);
  wire isSecRd = full8 & (fOp == fcs_pkg::OP_SEC_READ);
  wire isWrsr = (fOp == 8'h01) | (fOp == 8'h31) | (fOp == 8'h11);
  wire isSecErase = fOp == 8'h44;
  wire isSecPgm = fOp == 8'h42;
  wire isErase = (fOp == 8'h20) | (fOp == 8'h21) | (fOp == 8'h52) |
    (fOp == 8'h5c) | (fOp == 8'hd8) | (fOp == 8'hdc) | (fOp == 8'hc7) |
    (fOp == 8'h60);
  wire isPgm = (fOp == 8'h02) | (fOp == 8'h12) | (fOp == 8'h32) |
    (fOp == 8'h34);

  // ==========================================================
  // system side: mode state and timers
  fcs_pkg::fcs_mode_t mode_r;
  fcs_pkg::fcs_mode_t mode_nxt;
  logic [11:0] tmr_r;
  logic [11:0] tmr_nxt;
  logic wip_r;
  logic suspP_r;
  logic suspE_r;
  logic opErase_r;
  logic rstArmed_r;
  logic [11:0] latTmr_r;
  logic latSetsWip_r;

  wire stIdle = mode_r == fcs_pkg::FCS_IDLE;
  wire stPd = mode_r == fcs_pkg::FCS_PD;
  wire suspAny = suspP_r | suspE_r;
  wire tmrLast = tmr_r == 12'h001; // R22
  wire rstEnAcc = frameEnd & isRstEn & (stIdle | stPd); // R8
  wire rstAcc = frameEnd & isRst & rstArmed_r & (stIdle | stPd); // R6 R8
  wire suspAcc = frameEnd & isSusp & stIdle & wip_r & ~suspAny &
    (latTmr_r == '0); // R10
  wire resumeAcc = frameEnd & isResume & stIdle & suspAny & ~wip_r &
    (latTmr_r == '0); // R14
  wire pdAcc = frameEnd & isPd & stIdle & ~wip_r &
    (resBits_r == fcs_pkg::OPC_BITS); // R15 R17
  wire wakeAcc = frameEnd & isWake & stPd & ~wip_r; // R18 R21
  wire wakeLong = resBits_r >= fcs_pkg::ID_HDR; // R20
  wire restricted = (suspP_r & (isWrsr | isSecErase | isSecPgm | isErase |
    isPgm)) | (suspE_r & (isWrsr | isSecErase | isErase)); // R12 R13
  wire ownOp = isRstEn | isRst | isSusp | isResume | isPd | isWake |
    isSecRd;
  wire fwdAcc = frameEnd & full8 & stIdle & ~ownOp & ~restricted; // R16

  always_comb begin
    mode_nxt = mode_r;
    tmr_nxt = (tmr_r == '0) ? tmr_r : tmr_r - 12'h001;
    if (rstAcc) begin
      mode_nxt = fcs_pkg::FCS_RST_REC; // R7
      tmr_nxt = fcs_pkg::RST_CYC;
    end else begin
      unique case (mode_r)
        fcs_pkg::FCS_IDLE: begin
          if (pdAcc) begin
            mode_nxt = fcs_pkg::FCS_PD_ENTRY;
            tmr_nxt = fcs_pkg::DP_CYC;
          end
        end
        fcs_pkg::FCS_PD_ENTRY: begin
          if (tmrLast) begin
            mode_nxt = fcs_pkg::FCS_PD; // R16
          end
        end
        fcs_pkg::FCS_PD: begin
          if (wakeAcc) begin
            mode_nxt = fcs_pkg::FCS_WAKE;
            tmr_nxt = wakeLong ? fcs_pkg::RES2_CYC : fcs_pkg::RES1_CYC; // R20
          end
        end
        fcs_pkg::FCS_WAKE: begin
          if (tmrLast) begin
            mode_nxt = fcs_pkg::FCS_IDLE; // R18
          end
        end
        fcs_pkg::FCS_RST_REC: begin
          if (tmrLast) begin
            mode_nxt = fcs_pkg::FCS_IDLE; // R8
          end
        end
        default: begin
          mode_nxt = fcs_pkg::FCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= fcs_pkg::FCS_IDLE;
      tmr_r <= fcs_pkg::TMR_RST;
    end else begin
      mode_r <= mode_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // ==========================================================
  // system side: busy, suspend and volatile flags
  wire latLast = latTmr_r == 12'h001; // R11 R14
  wire startOk = opStart & stIdle & ~wip_r & ~suspAny & (latTmr_r == '0);
  wire [11:0] latTmr_nxt = suspAcc ? fcs_pkg::SUS_CYC :
    resumeAcc ? fcs_pkg::RESUME_CYC :
    (latTmr_r == '0) ? latTmr_r : latTmr_r - 12'h001;
  wire wip_nxt = rstAcc ? 1'b0 :
    (opDone & wip_r) ? 1'b0 :
    startOk ? 1'b1 :
    latLast ? latSetsWip_r : wip_r;
  wire suspP_nxt = ~rstAcc & ~resumeAcc &
    (suspP_r | (suspAcc & ~opErase_r)); // R11 R14
  wire suspE_nxt = ~rstAcc & ~resumeAcc &
    (suspE_r | (suspAcc & opErase_r)); // R11 R14
  wire wel_nxt = ~rstAcc & (welSet | (welFlag & ~(opDone & wip_r)));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wip_r <= 1'b0;
      suspP_r <= 1'b0;
      suspE_r <= 1'b0;
      opErase_r <= 1'b0;
      latTmr_r <= fcs_pkg::TMR_RST;
      latSetsWip_r <= 1'b0;
      welFlag <= 1'b0;
    end else begin
      wip_r <= wip_nxt; // R7
      suspP_r <= suspP_nxt;
      suspE_r <= suspE_nxt;
      latTmr_r <= rstAcc ? fcs_pkg::TMR_RST : latTmr_nxt;
      welFlag <= wel_nxt; // R7
      if (startOk) begin
        opErase_r <= opIsErase;
      end
      if (suspAcc | resumeAcc) begin
        latSetsWip_r <= resumeAcc;
      end
    end
  end

  // reset enable is forgotten by any frame that is not itself an accepted reset enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstArmed_r <= 1'b0;
    end else if (frameEnd) begin
      rstArmed_r <= rstEnAcc; // R6
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      contReadBits <= fcs_pkg::CONT_READ_RST;
      wrapBits <= fcs_pkg::WRAP_RST;
    end else if (rstAcc) begin
      contReadBits <= fcs_pkg::CONT_READ_RST; // R7
      wrapBits <= fcs_pkg::WRAP_RST;
    end else if (volLoad) begin
      contReadBits <= contReadIn;
      wrapBits <= wrapIn;
    end
  end

  // ==========================================================
  // system side: outputs and levels for the link side
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      engAbort <= 1'b0;
      fwdValid <= 1'b0;
      fwdOpcode <= '0;
      powerDown <= 1'b0;
      cmdBlocked <= 1'b0;
      rdOk_r <= 1'b0;
      idOk_r <= 1'b0;
      addr4Lvl_r <= 1'b0;
    end else begin
      engAbort <= rstAcc; // R7
      fwdValid <= fwdAcc;
      if (fwdAcc) begin
        fwdOpcode <= fOp;
      end
      powerDown <= mode_nxt == fcs_pkg::FCS_PD;
      cmdBlocked <= mode_nxt != fcs_pkg::FCS_IDLE;
      rdOk_r <= mode_nxt == fcs_pkg::FCS_IDLE; // R16
      idOk_r <= ~wip_nxt & ((mode_nxt == fcs_pkg::FCS_IDLE) |
        (mode_nxt == fcs_pkg::FCS_PD)); // R21
      addr4Lvl_r <= addr4Mode;
    end
  end

  assign wipFlag = wip_r;
  assign suspProgFlag = suspP_r;
  assign suspEraseFlag = suspE_r;
endmodule
`default_nettype wire

// file: testbench/fcs_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// spi host: sclk idles low and runs only inside frames
module fcs_spi_host (
  output logic sclk,
  output logic spiCsN,
  output logic spiSi,
  input wire logic spiSo
);
  initial begin
    sclk = 1'b0;
    spiCsN = 1'b1;
    spiSi = 1'b0;
  end
  // 30 ns bit time; the odd lead keeps edges off the system clock grid
  task automatic xfer(input int nOut, input logic [63:0] tx, input int nIn,
    output logic [63:0] rx);
    rx = 64'h0;
    #1.3 spiCsN = 1'b0;
    for (int i = nOut - 1; i >= 0; i--) begin
      spiSi = tx[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    for (int i = 0; i < nIn; i++) begin
      #15 sclk = 1'b1;
      rx = {rx[62:0], spiSo};
      #15 sclk = 1'b0;
    end
    #15 spiCsN = 1'b1;
    // a released line shows the inverse of its last bit, never a stale one
    spiSi = ~spiSi;
  endtask
endmodule
`default_nettype wire

// file: testbench/fcs_cmd_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_cmd_ctrl_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spiCsN,
  input wire logic spiSoOe,
  input wire logic wipFlag,
  input wire logic suspProgFlag,
  input wire logic suspEraseFlag,
  input wire logic welFlag,
  input wire logic [7:0] contReadBits,
  input wire logic [2:0] wrapBits,
  input wire logic powerDown,
  input wire logic cmdBlocked,
  input wire logic engAbort,
  input wire logic fwdValid,
  input wire logic [7:0] fwdOpcode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // interval counters
  wire logic susp = suspProgFlag | suspEraseFlag;
  logic [11:0] susCnt_r;
  logic [11:0] rstCnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      susCnt_r <= 12'h000;
      rstCnt_r <= 12'h000;
    end else begin
      susCnt_r <= (susp && wipFlag) ? susCnt_r + 12'h001 : 12'h000;
      rstCnt_r <= engAbort ? fcs_pkg::RST_CYC - 12'h002 :
        (rstCnt_r != 12'h000) ? rstCnt_r - 12'h001 : 12'h000;
    end
  end
  // ==========================================================
  // properties
  AST_OE_SELECTED: assert property (spiSoOe |-> !spiCsN &&
    (!cmdBlocked || powerDown))
    else $error("output driven while commands blocked");
  AST_SUSP_ONE: assert property (!(suspProgFlag && suspEraseFlag))
    else $error("both suspend flags set");
  AST_SUSP_BUSY: assert property ($rose(susp) |-> wipFlag)
    else $error("suspend taken while not busy");
  AST_SUSP_LAT: assert property (susCnt_r <= fcs_pkg::SUS_CYC + 12'h004)
    else $error("busy flag outlived suspend latency");
  AST_RESUME_WIP: assert property ($fell(susp) && !cmdBlocked &&
    !(engAbort || $past(engAbort)) |-> ##[0:30] wipFlag)
    else $error("busy not restored after resume");
  AST_PD_ENTRY: assert property ($rose(powerDown) |->
    !wipFlag && $past(cmdBlocked, 300))
    else $error("power-down entered early or while busy");
  AST_PD_BLOCKS: assert property (powerDown |-> cmdBlocked &&
    !fwdValid && !wipFlag)
    else $error("command activity during power-down");
  AST_ABORT_CLEARS: assert property (engAbort |=> !wipFlag && !susp &&
    !welFlag && !powerDown && contReadBits == fcs_pkg::CONT_READ_RST &&
    wrapBits == fcs_pkg::WRAP_RST && cmdBlocked)
    else $error("soft reset left state behind");
  AST_ABORT_PULSE: assert property (engAbort |=> !engAbort [*8])
    else $error("abort pulse too long");
  AST_RST_RECOVERY: assert property (rstCnt_r != 12'h000 |->
    cmdBlocked && !fwdValid)
    else $error("command taken during reset recovery");
  AST_FWD_ALLOWED: assert property (fwdValid |-> !cmdBlocked &&
    !(suspProgFlag && fwdOpcode == 8'h02) && !(susp && fwdOpcode == 8'h20) &&
    !(suspProgFlag && fwdOpcode == 8'h42) && !(susp && fwdOpcode == 8'h44))
    else $error("restricted opcode forwarded");
endmodule
bind fcs_cmd_ctrl fcs_cmd_ctrl_chk u_chk (.clock(clock), .rst_n(rst_n),
  .spiCsN(spiCsN), .spiSoOe(spiSoOe), .wipFlag(wipFlag),
  .suspProgFlag(suspProgFlag), .suspEraseFlag(suspEraseFlag),
  .welFlag(welFlag), .contReadBits(contReadBits), .wrapBits(wrapBits),
  .powerDown(powerDown), .cmdBlocked(cmdBlocked), .engAbort(engAbort),
  .fwdValid(fwdValid), .fwdOpcode(fwdOpcode));
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic addr4Mode = 1'b0, opStart = 1'b0, opIsErase = 1'b0, opDone = 1'b0;
  logic welSet = 1'b0, volLoad = 1'b0, secWrEn = 1'b0;
  int oeCnt = 0;
  logic [7:0] contReadIn = 8'h00, secWrData = 8'h00;
  logic [2:0] wrapIn = 3'h0;
  logic [12:0] secWrAddr = 13'h0000;
  logic sclk, spiCsN, spiSi, spiSo, spiSoOe, wipFlag, suspProgFlag;
  logic suspEraseFlag, welFlag, powerDown, cmdBlocked, engAbort, fwdValid;
  logic [7:0] contReadBits, fwdOpcode;
  logic [2:0] wrapBits;
  logic [63:0] rxd;
  int mismatches = 0, samples_checked = 0, cyc = 0, fwdCnt = 0, abortCnt = 0;
  always #4 clock = ~clock;
  fcs_cmd_ctrl DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk),
    .spiCsN(spiCsN), .spiSi(spiSi), .spiSo(spiSo), .spiSoOe(spiSoOe),
    .addr4Mode(addr4Mode), .opStart(opStart), .opIsErase(opIsErase),
    .opDone(opDone), .welSet(welSet), .volLoad(volLoad),
    .contReadIn(contReadIn), .wrapIn(wrapIn), .secWrEn(secWrEn),
    .secWrAddr(secWrAddr), .secWrData(secWrData), .wipFlag(wipFlag),
    .suspProgFlag(suspProgFlag), .suspEraseFlag(suspEraseFlag),
    .welFlag(welFlag), .contReadBits(contReadBits), .wrapBits(wrapBits),
    .powerDown(powerDown), .cmdBlocked(cmdBlocked), .engAbort(engAbort),
    .fwdValid(fwdValid), .fwdOpcode(fwdOpcode));
  fcs_spi_host host (.sclk(sclk), .spiCsN(spiCsN), .spiSi(spiSi),
    .spiSo(spiSo));
  // ==========================================================
  // monitors and helpers
  always @(posedge clock) begin
    cyc++;
    if (fwdValid === 1'b1) fwdCnt++;
    if (engAbort === 1'b1) abortCnt++;
    if (spiSoOe === 1'b1) oeCnt++;
    if (cyc == 40000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic cmd(input int n, input logic [63:0] tx, input int nIn);
    host.xfer(n, tx, nIn, rxd);
    wt(6);
  endtask
  task automatic start(input logic e);
    opIsErase <= e;
    opStart <= 1'b1;
    wt(1);
    opStart <= 1'b0;
    wt(2);
  endtask
  task automatic endOp();
    opDone <= 1'b1;
    wt(1);
    opDone <= 1'b0;
    wt(2);
  endtask
  task automatic secWr(input logic [3:0] rg, input logic [10:0] off,
    input logic [7:0] d);
    secWrEn <= 1'b1;
    secWrAddr <= {rg[1:0] - 2'h1, off};
    secWrData <= d;
    wt(1);
    secWrEn <= 1'b0;
    wt(1);
  endtask
  function automatic logic [63:0] hdrOf(input logic [3:0] rg,
    input logic [10:0] off, input logic four);
    if (four) return {16'h0, fcs_pkg::OP_SEC_READ, 16'h0, rg, 1'b0, off, 8'h0};
    return {24'h0, fcs_pkg::OP_SEC_READ, 8'h0, rg, 1'b0, off, 8'h0};
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    logic [3:0] rg;
    logic [10:0] off;
    logic [7:0] d0, d1, cr;
    int n;
    void'($urandom(32'h6bd9));
    wt(10);
    rst_n <= 1'b1;
    wt(4);
    // first pass starts on the last offset so the second byte wraps
    for (int i = 0; i < 7; i++) begin
      rg = (i == 6) ? 4'h4 : 4'(1 + $urandom_range(2));
      off = (i == 0) ? 11'h7ff : 11'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      if (i < 6) secWr(rg, off, d0);
      if (i < 6) secWr(rg, off + 11'h001, d1);
      addr4Mode <= i[0];
      wt(4);
      cmd(i[0] ? 48 : 40, hdrOf(rg, off, i[0]), 16);
      chk(rxd[15:0], (i == 6) ? 16'hffff : {d0, d1});
    end
    for (int e = 0; e < 2; e++) begin
      cmd(8, 64'h75, 0);
      chk({suspEraseFlag, suspProgFlag}, 16'h0);
      start(e[0]);
      cmd(8, 64'h75, 0);
      chk({suspEraseFlag, suspProgFlag, wipFlag}, e ? 16'h5 : 16'h3);
      wt(fcs_pkg::SUS_CYC + 4);
      chk(wipFlag, 16'h0);
      n = fwdCnt;
      cmd(8, 64'h20, 0);
      cmd(8, 64'h44, 0);
      cmd(8, 64'h02, 0);
      cmd(8, 64'h42, 0);
      chk(16'(fwdCnt - n), 16'(2 * e));
      chk(fwdOpcode, e ? 16'h0042 : 16'h0000);
      cmd(8, 64'h7a, 0);
      chk({suspEraseFlag, suspProgFlag}, 16'h0);
      wt(fcs_pkg::RESUME_CYC);
      chk(wipFlag, 16'h1);
      endOp();
    end
    start(1'b0);
    cmd(8, 64'hb9, 0);
    wt(fcs_pkg::DP_CYC + 4);
    chk(powerDown, 16'h0);
    endOp();
    cmd(9, 64'h172, 0);
    wt(fcs_pkg::DP_CYC + 4);
    chk(powerDown, 16'h0);
    cmd(8, 64'hb9, 0);
    chk(cmdBlocked, 16'h1);
    wt(fcs_pkg::DP_CYC);
    chk(powerDown, 16'h1);
    n = fwdCnt;
    cmd(8, 64'h02, 0);
    chk(16'(fwdCnt - n), 16'h0);
    cmd(8, 64'hab, 0);
    chk({powerDown, cmdBlocked}, 16'h1);
    wt(fcs_pkg::RES1_CYC - 12);
    chk(cmdBlocked, 16'h1);
    wt(20);
    chk(cmdBlocked, 16'h0);
    cmd(8, 64'hb9, 0);
    wt(fcs_pkg::DP_CYC + 4);
    cmd(32, 64'hab000000, 16);
    chk(rxd[15:0], {fcs_pkg::DEVICE_ID, fcs_pkg::DEVICE_ID});
    wt(fcs_pkg::RES1_CYC + 20);
    chk(cmdBlocked, 16'h1);
    wt(fcs_pkg::RES2_CYC - fcs_pkg::RES1_CYC);
    chk(cmdBlocked, 16'h0);
    start(1'b0);
    n = oeCnt;
    cmd(32, 64'hab000000, 16);
    chk({15'(oeCnt - n), cmdBlocked}, 16'h0);
    endOp();
    cr = 8'($urandom) | 8'h01;
    welSet <= 1'b1;
    volLoad <= 1'b1;
    contReadIn <= cr;
    wrapIn <= 3'($urandom) | 3'h1;
    wt(1);
    welSet <= 1'b0;
    volLoad <= 1'b0;
    wt(2);
    chk({wipFlag, suspProgFlag, suspEraseFlag, welFlag, contReadBits},
      {4'h1, cr});
    cmd(8, 64'h66, 0);
    cmd(8, 64'h05, 0);
    cmd(8, 64'h99, 0);
    chk({welFlag, cmdBlocked}, 16'h2);
    start(1'b1);
    cmd(8, 64'h75, 0);
    n = abortCnt;
    cmd(8, 64'h66, 0);
    cmd(8, 64'h99, 0);
    chk(16'(abortCnt - n), 16'h1);
    chk({wipFlag, suspEraseFlag, welFlag, contReadBits, wrapBits}, 16'h0);
    n = fwdCnt;
    cmd(8, 64'h02, 0);
    chk({15'(fwdCnt - n), cmdBlocked}, 16'h1);
    wt(fcs_pkg::RST_CYC);
    chk(cmdBlocked, 16'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
